// ### core/fbf_params.svh
// fbf_params.svh: named constants of the sheet feeder batch and fault controller.
// assumes a 40 MHz system clock; all slow timing runs from one 12.5 ms base tick.
`ifndef FBF_PARAMS_SVH
`define FBF_PARAMS_SVH

// clock and base tick
`define FBF_CLK_NS 25
`define FBF_TICK_US 12500
`define FBF_TICK_CYCLES (`FBF_TICK_US * 1000 / `FBF_CLK_NS)

// times in microseconds, as specified
`define FBF_HALF_DOUBLE_US 500000
`define FBF_HALF_MISS_US 1000000
`define FBF_HALF_TIMEOUT_US 62500
`define FBF_TIMEOUT_US 2000000
`define FBF_DELAY_STEP_US 100000

// the same times as counts of base ticks
`define FBF_HALF_DOUBLE_TICKS 8'(`FBF_HALF_DOUBLE_US / `FBF_TICK_US)
`define FBF_HALF_MISS_TICKS 8'(`FBF_HALF_MISS_US / `FBF_TICK_US)
`define FBF_HALF_TIMEOUT_TICKS 8'(`FBF_HALF_TIMEOUT_US / `FBF_TICK_US)
`define FBF_TIMEOUT_TICKS 8'(`FBF_TIMEOUT_US / `FBF_TICK_US)
`define FBF_DELAY_STEP_TICKS 8'(`FBF_DELAY_STEP_US / `FBF_TICK_US)

// setting limits and reset values
`define FBF_BATCH_MAX 7'h63
`define FBF_BATCH_CONT 7'h00
`define FBF_DELAY_MAX 5'h14
`define FBF_EOB_OFF 4'h0
`define FBF_COUNT_ONE 7'h01
`define FBF_TIMER_ZERO 8'h00
`define FBF_TIMER_ONE 8'h01

`endif

// ### core/fbf_pkg.sv
// fbf_pkg: types shared by the feeder controller files.
// assumes fbf_params.svh supplies the numeric constants.
package fbf_pkg;

  // controller modes
  typedef enum logic [2:0] {
    ST_POWERUP,
    ST_READY,
    ST_DELAY,
    ST_RUN,
    ST_STOP,
    ST_FAULT
  } fbf_state_t;

  // latched fault cause
  typedef enum logic [1:0] {
    FLT_NONE,
    FLT_DOUBLE,
    FLT_MISS,
    FLT_TIMEOUT
  } fbf_fault_t;

  // operator settings
  typedef struct packed {
    logic [6:0] batch_size;
    logic [3:0] eob_setting;
    logic [4:0] trig_delay;
    logic dd_enable;
    logic miss_enable;
    logic timeout_enable;
  } fbf_cfg_t;

  // panel lamps
  typedef struct packed {
    logic ready_lamp;
    logic stop_lamp;
    logic fault_lamp;
  } fbf_lamps_t;

endpackage

// ### core/fbf_tick.sv
// fbf_tick: prescaler giving a one-cycle pulse every CYCLES clocks.
// assumes a synchronous active-high reset.
`timescale 1ns/1ps
`include "fbf_params.svh"

module fbf_tick #(
  parameter int unsigned CYCLES = `FBF_TICK_CYCLES
) (
  input wire logic clk,
  input wire logic reset,
  output logic tick
);

  logic [19:0] cnt_reg;
  logic [19:0] cnt_next;
  logic tick_reg;
  logic tick_next;

  // wrap counter, pulse on the last count
  always_comb begin
    tick_next = 1'b0;
    cnt_next = cnt_reg + 20'h00001;
    if (cnt_reg == 20'(CYCLES - 1)) begin
      cnt_next = 20'h00000;
      tick_next = 1'b1;
    end
  end

  // register counter and pulse
  always_ff @(posedge clk) begin
    if (reset) begin
      cnt_reg <= 20'h00000;
      tick_reg <= 1'b0;
    end else begin
      cnt_reg <= cnt_next;
      tick_reg <= tick_next;
    end
  end

  assign tick = tick_reg;

endmodule

// ### core/fbf_ctrl.sv
// fbf_ctrl: batch, speed and fault control of a sheet feeder.
// assumes all inputs are synchronous to clk; buttons and sensors are active high,
// remote stop is active low.
`timescale 1ns/1ps
`include "fbf_params.svh"

module fbf_ctrl #(
  parameter int unsigned TICK_CYCLES = `FBF_TICK_CYCLES
) (
  input wire logic clk,
  input wire logic reset,
  input wire fbf_pkg::fbf_cfg_t cfg,
  input wire logic cycle_btn,
  input wire logic stop_btn,
  input wire logic fault_reset_btn,
  input wire logic jog_btn,
  input wire logic trig_sensor,
  input wire logic ext_trigger,
  input wire logic remote_stop_n,
  input wire logic sheet_sensor,
  input wire logic double_detect,
  output logic belt_run,
  output logic speed_indep,
  output logic ready_out,
  output logic trig_echo,
  output fbf_pkg::fbf_lamps_t lamps,
  output fbf_pkg::fbf_fault_t fault_code
);

  logic tick;
  fbf_pkg::fbf_state_t state_reg;
  fbf_pkg::fbf_state_t state_next;
  fbf_pkg::fbf_fault_t fault_reg;
  fbf_pkg::fbf_fault_t fault_next;
  logic [6:0] batch_reg;
  logic [6:0] batch_next;
  logic [6:0] count_reg;
  logic [6:0] count_next;
  logic [7:0] timer_reg;
  logic [7:0] timer_next;
  logic indep_reg;
  logic indep_next;
  logic [4:0] prev_reg;
  logic [4:0] prev_next;
  logic [7:0] blink_cnt_reg;
  logic [7:0] blink_cnt_next;
  logic blink_on_reg;
  logic blink_on_next;
  logic belt_reg;
  logic speed_reg;
  logic ready_reg;
  logic echo_reg;
  fbf_pkg::fbf_lamps_t lamps_reg;
  fbf_pkg::fbf_lamps_t lamps_next;
  logic [6:0] count_inc;
  logic [4:0] delay_set;
  logic [7:0] delay_ticks;
  logic [7:0] half_ticks;
  logic cycle_rise;
  logic trig_rise;
  logic reset_rise;
  logic stop_rise;
  logic sheet_rise;
  logic sheet_fall;
  logic stop_req;
  logic dd_hit;
  logic eob_ok;
  logic active;
  logic in_cycle;
  logic miss_hit;
  logic timeout_hit;

  // base tick for every blink, delay and timeout count
  fbf_tick #(
    .CYCLES(TICK_CYCLES)
  ) u_tick (
    .clk(clk),
    .reset(reset),
    .tick(tick)
  );

  // edges of buttons and sensors against last cycle's levels; the stop button is taken as a level
  assign cycle_rise = cycle_btn & ~prev_reg[0];
  assign trig_rise = cycle_rise | (trig_sensor & ~prev_reg[1]) | (ext_trigger & ~prev_reg[2]);
  assign reset_rise = fault_reset_btn & ~prev_reg[3];
  assign sheet_rise = sheet_sensor & ~prev_reg[4];
  assign sheet_fall = ~sheet_sensor & prev_reg[4];
  assign stop_rise = stop_btn;
  assign stop_req = stop_rise | ~remote_stop_n;
  assign dd_hit = cfg.dd_enable & double_detect;
  assign count_inc = count_reg + `FBF_COUNT_ONE;
  assign in_cycle = (state_reg == fbf_pkg::ST_DELAY) || (state_reg == fbf_pkg::ST_RUN);
  assign active = in_cycle || (state_reg == fbf_pkg::ST_READY);

  // speed switch allowed only for 0 < N < batch
  assign eob_ok = (cfg.eob_setting != `FBF_EOB_OFF) && ({3'h0, cfg.eob_setting} < batch_reg);

  // delay setting clamped to 2.0 s, in tenth-second steps
  assign delay_set = (cfg.trig_delay > `FBF_DELAY_MAX) ? `FBF_DELAY_MAX : cfg.trig_delay;
  assign delay_ticks = 8'({3'h0, delay_set} * `FBF_DELAY_STEP_TICKS);

  // extra trigger during a batched cycle
  assign miss_hit = in_cycle && trig_rise && cfg.miss_enable && (batch_reg != `FBF_BATCH_CONT);

  // two seconds without any sheet edge in a batched run
  assign timeout_hit = (state_reg == fbf_pkg::ST_RUN) && cfg.timeout_enable && tick &&
                       (batch_reg != `FBF_BATCH_CONT) && !sheet_rise && !sheet_fall &&
                       (timer_reg == `FBF_TIMEOUT_TICKS - `FBF_TIMER_ONE);

  // mode sequencing, counting and fault capture
  always_comb begin
    state_next = state_reg;
    fault_next = fault_reg;
    count_next = count_reg;
    timer_next = timer_reg;
    indep_next = indep_reg;
    prev_next = {sheet_sensor, fault_reset_btn, ext_trigger, trig_sensor, cycle_btn};
    // batch size taken only outside a cycle
    batch_next = batch_reg;
    if (!in_cycle) begin
      batch_next = (cfg.batch_size > `FBF_BATCH_MAX) ? `FBF_BATCH_MAX : cfg.batch_size;
    end
    case (state_reg)
      fbf_pkg::ST_POWERUP: begin
        if (reset_rise && remote_stop_n) begin
          state_next = fbf_pkg::ST_READY;
        end
      end
      fbf_pkg::ST_READY: begin
        // triggers only start a cycle from ready
        if (trig_rise) begin
          count_next = 7'h00;
          indep_next = 1'b0;
          timer_next = delay_ticks;
          state_next = (delay_ticks == `FBF_TIMER_ZERO) ? fbf_pkg::ST_RUN : fbf_pkg::ST_DELAY;
          if (delay_ticks == `FBF_TIMER_ZERO) begin
            timer_next = `FBF_TIMER_ZERO;
          end
        end
      end
      fbf_pkg::ST_DELAY: begin
        if (timer_reg == `FBF_TIMER_ZERO) begin
          state_next = fbf_pkg::ST_RUN;
        end else if (tick) begin
          timer_next = timer_reg - `FBF_TIMER_ONE;
        end
      end
      fbf_pkg::ST_RUN: begin
        // timer counts ticks since the last sheet change
        if (sheet_rise || sheet_fall) begin
          timer_next = `FBF_TIMER_ZERO;
        end else if (tick && timer_reg != `FBF_TIMEOUT_TICKS) begin
          timer_next = timer_reg + `FBF_TIMER_ONE;
        end
        // leading edge of the first end-of-batch piece
        if (sheet_rise && eob_ok && (count_reg == batch_reg - {3'h0, cfg.eob_setting})) begin
          indep_next = 1'b1;
        end
        // trailing edge counts a dispensed piece
        if (sheet_fall) begin
          count_next = count_inc;
          if (batch_reg != `FBF_BATCH_CONT && count_inc == batch_reg) begin
            state_next = fbf_pkg::ST_READY;
            indep_next = 1'b0;
          end
        end
      end
      fbf_pkg::ST_STOP: begin
        // remote stop held keeps the feeder stopped
        if (reset_rise && remote_stop_n) begin
          state_next = fbf_pkg::ST_READY;
        end
      end
      fbf_pkg::ST_FAULT: begin
        // a double must be removed before reset works
        if (reset_rise && remote_stop_n &&
            !(fault_reg == fbf_pkg::FLT_DOUBLE && double_detect)) begin
          state_next = fbf_pkg::ST_READY;
          fault_next = fbf_pkg::FLT_NONE;
        end
      end
      default: begin
        state_next = fbf_pkg::ST_POWERUP;
      end
    endcase
    // first fault wins, fixed priority on a tie; stop comes after
    if (active) begin
      if (dd_hit) begin
        state_next = fbf_pkg::ST_FAULT;
        fault_next = fbf_pkg::FLT_DOUBLE;
      end else if (timeout_hit) begin
        state_next = fbf_pkg::ST_FAULT;
        fault_next = fbf_pkg::FLT_TIMEOUT;
      end else if (miss_hit) begin
        state_next = fbf_pkg::ST_FAULT;
        fault_next = fbf_pkg::FLT_MISS;
      end else if (stop_req) begin
        state_next = fbf_pkg::ST_STOP;
      end
      if (state_next != fbf_pkg::ST_RUN) begin
        indep_next = 1'b0;
      end
    end
  end

  // register mode state
  always_ff @(posedge clk) begin
    if (reset) begin
      state_reg <= fbf_pkg::ST_POWERUP;
      fault_reg <= fbf_pkg::FLT_NONE;
      batch_reg <= `FBF_BATCH_CONT;
      count_reg <= 7'h00;
      timer_reg <= `FBF_TIMER_ZERO;
      indep_reg <= 1'b0;
      prev_reg <= 5'h00;
    end else begin
      state_reg <= state_next;
      fault_reg <= fault_next;
      batch_reg <= batch_next;
      count_reg <= count_next;
      timer_reg <= timer_next;
      indep_reg <= indep_next;
      prev_reg <= prev_next;
    end
  end

  // half period per fault kind
  assign half_ticks = (fault_next == fbf_pkg::FLT_DOUBLE) ? `FBF_HALF_DOUBLE_TICKS :
                      (fault_next == fbf_pkg::FLT_MISS) ? `FBF_HALF_MISS_TICKS :
                      `FBF_HALF_TIMEOUT_TICKS;

  // blink phase and panel outputs, all taken from the next mode
  always_comb begin
    blink_cnt_next = `FBF_TIMER_ZERO;
    blink_on_next = 1'b1;
    if (state_reg == fbf_pkg::ST_FAULT && state_next == fbf_pkg::ST_FAULT) begin
      blink_cnt_next = blink_cnt_reg;
      blink_on_next = blink_on_reg;
      if (tick) begin
        if (blink_cnt_reg == half_ticks - `FBF_TIMER_ONE) begin
          blink_cnt_next = `FBF_TIMER_ZERO;
          blink_on_next = ~blink_on_reg;
        end else begin
          blink_cnt_next = blink_cnt_reg + `FBF_TIMER_ONE;
        end
      end
    end
    lamps_next.ready_lamp = (state_next == fbf_pkg::ST_READY);
    lamps_next.stop_lamp = (state_next == fbf_pkg::ST_STOP);
    lamps_next.fault_lamp = 1'b0;
    case (state_next)
      fbf_pkg::ST_POWERUP: lamps_next.fault_lamp = 1'b1;
      fbf_pkg::ST_STOP: lamps_next.fault_lamp = 1'b1;
      fbf_pkg::ST_FAULT: lamps_next.fault_lamp = blink_on_next;
      default: lamps_next.fault_lamp = 1'b0;
    endcase
  end

  // register outputs; jog turns the belts only in ready mode
  always_ff @(posedge clk) begin
    if (reset) begin
      blink_cnt_reg <= `FBF_TIMER_ZERO;
      blink_on_reg <= 1'b1;
      belt_reg <= 1'b0;
      speed_reg <= 1'b0;
      ready_reg <= 1'b0;
      echo_reg <= 1'b0;
      lamps_reg <= 3'h0;
    end else begin
      blink_cnt_reg <= blink_cnt_next;
      blink_on_reg <= blink_on_next;
      belt_reg <= (state_next == fbf_pkg::ST_RUN) ||
                  (state_next == fbf_pkg::ST_READY && jog_btn);
      speed_reg <= indep_next;
      ready_reg <= (state_next == fbf_pkg::ST_READY);
      echo_reg <= cycle_btn | trig_sensor | ext_trigger;
      lamps_reg <= lamps_next;
    end
  end

  assign belt_run = belt_reg;
  assign speed_indep = speed_reg;
  assign ready_out = ready_reg;
  assign trig_echo = echo_reg;
  assign lamps = lamps_reg;
  assign fault_code = fault_reg;

  // checks on the control behaviour
  a_batch_end_stop: assert property (@(posedge clk) disable iff (reset)
    (state_reg == fbf_pkg::ST_RUN && sheet_fall && !dd_hit && !timeout_hit && !miss_hit &&
     !stop_req && batch_reg != `FBF_BATCH_CONT && count_inc == batch_reg)
    |=> (state_reg == fbf_pkg::ST_READY) && !speed_indep)
    else $error("batch end did not return to ready");

  a_count_trailing: assert property (@(posedge clk) disable iff (reset)
    (state_reg == fbf_pkg::ST_RUN && !sheet_fall) |=> (count_reg == $past(count_reg)))
    else $error("count moved without a trailing edge");

  a_cont_keeps_run: assert property (@(posedge clk) disable iff (reset)
    (state_reg == fbf_pkg::ST_RUN && batch_reg == `FBF_BATCH_CONT && !stop_req && !dd_hit)
    |=> (state_reg == fbf_pkg::ST_RUN) && belt_run)
    else $error("continuous run ended without stop");

  a_batch_frozen: assert property (@(posedge clk) disable iff (reset)
    in_cycle |=> (batch_reg == $past(batch_reg)))
    else $error("batch size changed during a cycle");

  a_start_ready_only: assert property (@(posedge clk) disable iff (reset)
    (state_reg == fbf_pkg::ST_STOP || state_reg == fbf_pkg::ST_FAULT ||
     state_reg == fbf_pkg::ST_POWERUP)
    |=> (state_reg != fbf_pkg::ST_DELAY) && (state_reg != fbf_pkg::ST_RUN))
    else $error("cycle started outside ready");

  a_double_fault: assert property (@(posedge clk) disable iff (reset)
    (active && dd_hit) |=> (fault_reg == fbf_pkg::FLT_DOUBLE) && !belt_run && !ready_out &&
    !lamps.ready_lamp)
    else $error("double detect did not fault");

  a_dd_disabled: assert property (@(posedge clk) disable iff (reset)
    (!cfg.dd_enable && fault_reg != fbf_pkg::FLT_DOUBLE) |=> (fault_reg != fbf_pkg::FLT_DOUBLE))
    else $error("double fault while disabled");

  a_eob_switch: assert property (@(posedge clk) disable iff (reset)
    (state_reg == fbf_pkg::ST_RUN && sheet_rise && eob_ok && !stop_req && !dd_hit &&
     !miss_hit && count_reg == batch_reg - {3'h0, cfg.eob_setting}) |=> speed_indep)
    else $error("end of batch speed not taken");

  a_eob_blocked: assert property (@(posedge clk) disable iff (reset)
    (!indep_reg && !eob_ok) |=> !speed_indep)
    else $error("speed changed with invalid setting");

  a_stop_lamps: assert property (@(posedge clk) disable iff (reset)
    (state_reg == fbf_pkg::ST_STOP) |-> lamps.stop_lamp && lamps.fault_lamp && !ready_out)
    else $error("stop mode lamps wrong");

  a_blink_steady: assert property (@(posedge clk) disable iff (reset)
    (state_reg == fbf_pkg::ST_FAULT && $past(state_reg) == fbf_pkg::ST_FAULT && !$past(tick))
    |-> $stable(lamps.fault_lamp))
    else $error("fault lamp changed off a tick");

endmodule

// ### testbench/fbf_sheet_model.sv
// fbf_sheet_model: stream of sheets seen by the discharge sheet sensor.
// assumes the belts move sheets only while belt_run is high.
`timescale 1ns/1ps
module fbf_sheet_model (
  input wire logic clk,
  input wire logic belt_run,
  input wire logic stall,
  output logic sheet_sensor
);
  logic [3:0] phase_reg = 4'h0;

  // sheets advance only while belts turn; stall models an empty hopper
  always @(posedge clk) begin
    if (belt_run && !stall) begin
      phase_reg <= phase_reg + 4'h1;
    end
  end

  // sensor lit for 6 clocks, dark for 10; level freezes when belts stop
  assign sheet_sensor = (phase_reg >= 4'hA);
endmodule

// ### testbench/tb.sv
// tb: self-checking bench for the feeder batch and fault controller.
// assumes fbf_pkg and fbf_ctrl compiled first; prescaler shortened to 4 clocks.
`timescale 1ns/1ps
module tb;
  logic clk = 1'b0;
  logic reset = 1'b1;
  logic stop_btn = 1'b0;
  logic double_detect = 1'b0;
  logic stall = 1'b0;
  logic remote_stop_n = 1'b1;
  logic [3:0] btns = 4'h0;
  fbf_pkg::fbf_cfg_t cfg = '0;
  logic belt_run, speed_indep, ready_out, trig_echo, sheet_sensor;
  fbf_pkg::fbf_lamps_t lamps;
  fbf_pkg::fbf_fault_t fault_code;
  fbf_pkg::fbf_fault_t prev_fault = fbf_pkg::FLT_NONE;
  logic [13:0] cyc_q[$];
  logic [10:0] flt_q[$];
  logic [6:0] pieces = 7'h00;
  logic [6:0] indep_at = 7'h7F;
  logic prev_belt = 1'b0, prev_sheet = 1'b0, prev_indep = 1'b0;
  int miscompares = 0, total_checks = 0, flt_done = 0;

  // 40 MHz clock
  always begin
    #12.5 clk = ~clk;
  end

  fbf_ctrl #(.TICK_CYCLES(4)) DUT (
    .clk(clk), .reset(reset), .cfg(cfg), .cycle_btn(btns[0]), .stop_btn(stop_btn),
    .fault_reset_btn(btns[3]), .jog_btn(1'b0), .trig_sensor(btns[1]),
    .ext_trigger(btns[2]), .remote_stop_n(remote_stop_n), .sheet_sensor(sheet_sensor),
    .double_detect(double_detect), .belt_run(belt_run), .speed_indep(speed_indep),
    .ready_out(ready_out), .trig_echo(trig_echo), .lamps(lamps), .fault_code(fault_code)
  );

  fbf_sheet_model sheets (
    .clk(clk), .belt_run(belt_run), .stall(stall), .sheet_sensor(sheet_sensor)
  );

  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    total_checks++;
    if (got !== exp) begin
      miscompares++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // run result: pieces counted and piece count at the speed switch
  task automatic cmp_cycle(input logic [13:0] got, input logic [13:0] exp);
    chk({2'h0, got}, {2'h0, exp});
  endtask

  // fault result: latched cause and dark half of the blink in clocks
  task automatic cmp_fault(input logic [10:0] got, input logic [10:0] exp);
    chk({5'h0, got}, {5'h0, exp});
  endtask

  task automatic final_report;
    $display("checks=%0d mismatches=%0d", total_checks, miscompares);
    if (miscompares == 0 && total_checks > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask

  // one press of a button; bits 0..2 are triggers, bit 3 fault/reset
  task automatic press(input int k);
    @(posedge clk) btns[k] <= 1'b1;
    @(posedge clk) btns[k] <= 1'b0;
    #1;
    if (k < 3) chk(16'(trig_echo), 16'h0001);
  endtask

  task automatic wait_ready;
    for (int n = 0; n < 3000 && ready_out !== 1'b1; n++) @(posedge clk);
    #1;
    chk(16'(ready_out), 16'h0001);
  endtask

  task automatic wait_flt(input int t);
    for (int n = 0; n < 2000 && flt_done < t; n++) @(posedge clk);
    chk(16'(flt_done), 16'(t));
  endtask

  task automatic run_batch(input logic [6:0] b, input logic [3:0] e, input int k);
    logic [6:0] ia;
    ia = (e != 4'h0 && 7'(e) < b) ? b - 7'(e) : 7'h7F;
    @(posedge clk) begin
      cfg.batch_size <= b;
      cfg.eob_setting <= e;
    end
    cyc_q.push_back({b, ia});
    press(k);
    @(posedge clk) cfg.batch_size <= b + 7'h01;
    wait_ready();
    $display("test batch %0d eob %0d done", b, e);
  endtask

  // run watcher: trailing edges per run, switch point seen on a lit sensor
  always @(posedge clk) begin
    if (belt_run && prev_sheet && !sheet_sensor) pieces = pieces + 7'h01;
    if (speed_indep && !prev_indep) indep_at = sheet_sensor ? pieces : 7'h7E;
    if (prev_belt && !belt_run) begin
      if (fault_code === fbf_pkg::FLT_NONE) begin
        if (cyc_q.size() == 0) chk(16'h0000, 16'hFFFF);
        else cmp_cycle({pieces, indep_at}, cyc_q.pop_front());
      end
      pieces = 7'h00;
      indep_at = 7'h7F;
    end
    prev_belt = belt_run;
    prev_sheet = sheet_sensor;
    prev_indep = speed_indep;
  end

  // fault watcher: on a new cause, time one dark half of the lamp
  always @(posedge clk) begin
    int h;
    if (fault_code !== prev_fault && fault_code !== fbf_pkg::FLT_NONE) begin
      for (h = 0; h < 400 && lamps.fault_lamp !== 1'b0; h++) @(posedge clk);
      for (h = 0; h < 400 && lamps.fault_lamp !== 1'b1; h++) @(posedge clk);
      if (flt_q.size() == 0) chk(16'h0000, 16'hFFFF);
      else cmp_fault({fault_code, 9'(h)}, flt_q.pop_front());
      flt_done++;
    end
    prev_fault = fault_code;
  end

  // watchdog sized well past the full sequence
  initial begin
    repeat (40000) @(posedge clk);
    miscompares++;
    final_report();
  end

  initial begin
    void'($urandom(84));
    repeat (6) @(posedge clk);
    reset <= 1'b0;
    repeat (2) @(posedge clk);
    #1;
    chk(16'(lamps), 16'h0001);
    press(3);
    wait_ready();
    chk(16'(lamps), 16'h0004);
    $display("test power-up done");
    // detector reports while disabled must not disturb the runs
    @(posedge clk) double_detect <= 1'b1;
    run_batch(7'h02, 4'h1, 0);
    run_batch(7'h05, 4'h0, 1);
    run_batch(7'h03, 4'h3, 2);
    run_batch(7'h04, 4'h5, 0);
    @(posedge clk) double_detect <= 1'b0;
    for (int i = 0; i < 4; i++) run_batch(7'(1 + $urandom % 20), 4'($urandom % 16), $urandom % 3);
    // delayed start of 0.2 s: 64 clocks, less up to one tick of prescaler phase
    @(posedge clk) begin
      cfg.trig_delay <= 5'h02;
      cfg.batch_size <= 7'h02;
      cfg.eob_setting <= 4'h0;
    end
    cyc_q.push_back({7'h02, 7'h7F});
    press(1);
    repeat (61) @(posedge clk);
    #1;
    chk(16'(belt_run), 16'h0000);
    repeat (9) @(posedge clk);
    #1;
    chk(16'(belt_run), 16'h0001);
    wait_ready();
    $display("test trigger delay done");
    // continuous run, extra trigger ignored, ended by stop
    @(posedge clk) begin
      cfg.trig_delay <= 5'h00;
      cfg.batch_size <= 7'h00;
      cfg.miss_enable <= 1'b1;
    end
    cyc_q.push_back({7'h03, 7'h7F});
    press(0);
    press(2);
    for (int n = 0; n < 500 && pieces != 7'h03; n++) @(posedge clk);
    stop_btn <= 1'b1;
    #1;
    chk(16'(belt_run), 16'h0001);
    @(posedge clk) stop_btn <= 1'b0;
    repeat (2) @(posedge clk);
    #1;
    chk(16'({lamps, ready_out}), 16'h0006);
    press(0);
    repeat (2) @(posedge clk);
    #1;
    chk(16'(belt_run), 16'h0000);
    press(3);
    wait_ready();
    $display("test continuous and stop done");
    // remote stop held low stops the feeder and blocks fault/reset
    @(posedge clk) remote_stop_n <= 1'b0;
    repeat (2) @(posedge clk);
    #1;
    chk(16'({lamps, ready_out}), 16'h0006);
    press(3);
    repeat (2) @(posedge clk);
    #1;
    chk(16'({lamps, ready_out}), 16'h0006);
    @(posedge clk) remote_stop_n <= 1'b1;
    press(3);
    wait_ready();
    $display("test remote stop done");
    // double feed mid-batch; reset refused while the double remains
    @(posedge clk) begin
      cfg.batch_size <= 7'h09;
      cfg.dd_enable <= 1'b1;
    end
    flt_q.push_back({fbf_pkg::FLT_DOUBLE, 9'h0A0});
    press(0);
    repeat (30) @(posedge clk);
    double_detect <= 1'b1;
    wait_flt(1);
    chk(16'({belt_run, ready_out, lamps.ready_lamp}), 16'h0000);
    press(3);
    repeat (2) @(posedge clk);
    #1;
    chk(16'(fault_code), 16'(fbf_pkg::FLT_DOUBLE));
    @(posedge clk) double_detect <= 1'b0;
    press(3);
    wait_ready();
    $display("test double detect done");
    // second trigger before the batch completes
    flt_q.push_back({fbf_pkg::FLT_MISS, 9'h140});
    press(0);
    repeat (20) @(posedge clk);
    press(2);
    wait_flt(2);
    chk(16'({belt_run, ready_out}), 16'h0000);
    press(3);
    wait_ready();
    $display("test miss done");
    // empty hopper: no sensor change for two seconds
    @(posedge clk) begin
      cfg.timeout_enable <= 1'b1;
      stall <= 1'b1;
    end
    flt_q.push_back({fbf_pkg::FLT_TIMEOUT, 9'h014});
    press(1);
    wait_flt(3);
    double_detect <= 1'b1;
    repeat (3) @(posedge clk);
    #1;
    chk(16'(fault_code), 16'(fbf_pkg::FLT_TIMEOUT));
    @(posedge clk) begin
      double_detect <= 1'b0;
      stall <= 1'b0;
    end
    press(3);
    wait_ready();
    $display("test timeout done");
    final_report();
  end
endmodule
